/* File: hdl/dio_pkg.sv */
// Package with constants, register map and mode type for the isolated digital I/O port.
//
// Contract
// [R1] One eight-line input port and one separate eight-line output port.
// [R2] Each port is 8 bits wide; one access moves all lines at once.
// [R3] After reset every output line is inactive until the host writes.
// [R4] Input port bit reads 0 for a low line and 1 for a high line.
// [R5] Output polarity is inverted: written 0 drives high, written 1 drives low.
// [R6] Host waits about 1 ms between output write and input readback.
// [R7] Any change on an interrupt-enabled input line raises the host interrupt; the code raises it only in continuous mode.
// [R8] Change interrupts are enabled or disabled per input line.
// [R9] Each input is debounced; transitions are ignored for about 1 ms.
// [R10] Event report low byte holds the changed-lines mask, bit 0 is line 0.
// [R11] Event report bits 16 to 23 hold the captured input state, line 0 first.
// [R12] Single-value port accesses complete on their own and carry no interrupt status.
// [R13] In continuous mode each interrupt yields an event with mask and input state.
// [R14] Host selects port, width 8 and gain 1; gain is ignored.
// [R15] Each debounced input is compared with its previous value; a difference sets a sticky flag.
// [R16] Interrupt stays high while an enabled flag is set; reading the report clears those flags. The code holds it for flags only in continuous mode.
// [R17] The input snapshot is latched in the cycle the interrupt is raised.
package dio_pkg;
   localparam int PORT_WIDTH = 8;
   localparam int ADDR_WIDTH = 4;
   localparam int CLK_FREQ_HZ = 100000000;
   localparam int DEBOUNCE_TIME_US = 1000;
   localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1000000) * DEBOUNCE_TIME_US;
   localparam logic [3:0] ADDR_INPUT = 4'h0;
   localparam logic [3:0] ADDR_OUTPUT = 4'h1;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h2;
   localparam logic [3:0] ADDR_CONTROL = 4'h3;
   localparam logic [3:0] ADDR_EVENT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_CLEAR = 4'h6;
   localparam logic [3:0] ADDR_INT_ENABLE = 4'h7;
   localparam int CTRL_CONT_BIT = 0;
   localparam int MASK_LSB = 0;
   localparam int STATE_LSB = 16;
   localparam int STAT_CHANGE_BIT = 0;
   localparam int STAT_OVERRUN_BIT = 1;
   localparam logic [7:0] OUTPUT_RESET = 8'h00;
   localparam logic [1:0] STAT_WIDTH_ZERO = 2'h0;
   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_CONT = 2'b01
   } mode_t;
endpackage

/* File: hdl/input_filter.sv */
// Per-line debounce filter with a settling counter for each input line.
`timescale 1ns/1ps
module input_filter
   import dio_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH,
   parameter int SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] raw_in,
   output logic [WIDTH-1:0] clean_out
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   logic [CW-1:0] count_reg [WIDTH];

   // A line must hold its new level for the whole settling time before it is accepted. [R9]
   for (genvar i = 0; i < WIDTH; i++) begin : g_line
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            count_reg[i] <= '0;
            clean_out[i] <= 1'b0;
         end else if (raw_in[i] == clean_out[i]) begin
            count_reg[i] <= '0;
         end else if (count_reg[i] == CW'(SETTLE_CYCLES - 1)) begin
            count_reg[i] <= '0;
            clean_out[i] <= raw_in[i]; // [R9]
         end else begin
            count_reg[i] <= count_reg[i] + CW'(1);
         end
      end
   end
endmodule

/* File: hdl/change_detect.sv */
// Change detector that keeps sticky per-line changed flags.
`timescale 1ns/1ps
module change_detect
   import dio_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] clean_in,
   input wire logic [WIDTH-1:0] clear_mask,
   output logic [WIDTH-1:0] changed,
   output logic [WIDTH-1:0] prev_out
);
   logic [WIDTH-1:0] diff;

   assign diff = clean_in ^ prev_out; // [R15]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_out <= '0;
      end else begin
         prev_out <= clean_in;
      end
   end

   // A new change wins over a clear in the same cycle, so no edge is lost.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         changed <= '0;
      end else begin
         changed <= (changed & ~clear_mask) | diff; // [R15]
      end
   end
endmodule

/* File: hdl/dio_port.sv */
// Top of the isolated eight-line digital I/O port with change-of-state interrupt.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module dio_port
   import dio_pkg::*;
#(
   parameter int WIDTH = PORT_WIDTH,
   parameter int SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [WIDTH-1:0] DIN,
   output logic [WIDTH-1:0] DOUT_ON,
   input wire logic [ADDR_WIDTH-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [WIDTH-1:0] clean;
   logic [WIDTH-1:0] changed;
   logic [WIDTH-1:0] clear_mask;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] line_en_reg;
   logic [WIDTH-1:0] snap_reg;
   logic [WIDTH-1:0] mask_reg;
   logic [1:0] status_reg;
   logic [1:0] int_en_reg;
   mode_t mode_reg;
   logic [31:0] rdata_next;
   logic [WIDTH-1:0] pending;
   logic event_set;
   logic rd_event;

   input_filter #(.WIDTH(WIDTH), .SETTLE_CYCLES(SETTLE_CYCLES)) u_filter (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .raw_in(DIN), // [R1]
      .clean_out(clean)
   );

   change_detect #(.WIDTH(WIDTH)) u_detect (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .clean_in(clean),
      .clear_mask(clear_mask),
      .changed(changed),
      .prev_out()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // All set flags of enabled lines, including those the latched report already holds.
   assign pending = changed & line_en_reg; // [R8]
   assign rd_event = RD && (ADDR == ADDR_EVENT);
   // Reading the report releases only the flags that were latched into it. [R16]
   assign clear_mask = rd_event ? mask_reg : '0;
   assign event_set = (pending & ~mask_reg) != '0;

   // Output register; power-up value leaves every isolated switch open. [R3]
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_reg <= OUTPUT_RESET; // [R3]
      end else if (WR && ADDR == ADDR_OUTPUT) begin
         out_reg <= WDATA[WIDTH-1:0]; // [R2]
      end
   end

   // A written 1 turns the switch on and pulls the line low, a written 0 leaves it high. [R5]
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DOUT_ON <= '0; // [R3]
      end else begin
         DOUT_ON <= out_reg; // [R5]
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         line_en_reg <= '0;
         mode_reg <= MODE_SINGLE;
         int_en_reg <= '0;
      end else if (WR) begin
         if (ADDR == ADDR_IRQ_ENABLE) begin
            line_en_reg <= WDATA[WIDTH-1:0]; // [R8]
         end
         if (ADDR == ADDR_CONTROL) begin
            mode_reg <= WDATA[CTRL_CONT_BIT] ? MODE_CONT : MODE_SINGLE; // [R13]
         end
         if (ADDR == ADDR_INT_ENABLE) begin
            int_en_reg <= WDATA[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The mask and the snapshot are taken together so the report stays consistent.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mask_reg <= '0;
         snap_reg <= '0;
      end else if (mode_reg == MODE_CONT && event_set && !rd_event) begin
         mask_reg <= mask_reg | pending; // [R13]
         snap_reg <= clean; // [R17]
      end else if (rd_event) begin
         mask_reg <= '0; // [R16]
      end
   end

   // Sticky status: bit 0 a new event, bit 1 an event while one was unread; set wins.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         status_reg <= STAT_WIDTH_ZERO;
      end else begin
         status_reg <= (WR && ADDR == ADDR_CLEAR) ? (status_reg & ~WDATA[1:0]) : status_reg;
         if (mode_reg == MODE_CONT && event_set) begin
            status_reg[STAT_CHANGE_BIT] <= 1'b1; // [R7]
            if (mask_reg != '0) begin
               status_reg[STAT_OVERRUN_BIT] <= 1'b1;
            end
         end
      end
   end

   // The line stays high while any enabled change is unread in continuous mode or an enabled status bit is set. [R16]
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= (mode_reg == MODE_CONT && (pending != '0)) // [R7]
            || ((status_reg & int_en_reg) != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reads complete in one cycle with no wait; only a read of the event report clears interrupt flags. [R12]
   always_comb begin
      rdata_next = '0;
      unique case (ADDR)
         ADDR_INPUT: rdata_next[WIDTH-1:0] = clean; // [R4]
         ADDR_OUTPUT: rdata_next[WIDTH-1:0] = out_reg;
         ADDR_IRQ_ENABLE: rdata_next[WIDTH-1:0] = line_en_reg;
         ADDR_CONTROL: rdata_next[CTRL_CONT_BIT] = (mode_reg == MODE_CONT);
         ADDR_EVENT: begin
            rdata_next[MASK_LSB +: WIDTH] = mask_reg; // [R10]
            rdata_next[STATE_LSB +: WIDTH] = snap_reg; // [R11]
         end
         ADDR_STATUS: rdata_next[1:0] = status_reg;
         ADDR_INT_ENABLE: rdata_next[1:0] = int_en_reg;
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= '0;
      end else if (RD) begin
         RDATA <= rdata_next;
      end else begin
         RDATA <= '0;
      end
   end
endmodule

/* File: verification/dio_port_properties.sv */
// Concurrent checks on the ports of the digital I/O port.
`timescale 1ns/1ps
module dio_port_properties
   import dio_pkg::*;
#(
   parameter int SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [PORT_WIDTH-1:0] DIN,
   input wire logic [PORT_WIDTH-1:0] DOUT_ON,
   input wire logic [ADDR_WIDTH-1:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic IRQ
);
   // Quiet-input count and recent accesses are what may explain an IRQ edge.
   int since;
   logic [7:0] din_q;
   logic [2:0] acc_q;
   logic [1:0] ow_q;
   logic rd_q;
   logic [3:0] ra_q;
   logic irq_q;
   // The snapshot matches the pins only if the inputs had settled when it was taken.
   logic snap_ok;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         {since, din_q, acc_q, ow_q, rd_q, ra_q, irq_q, snap_ok} <= '0;
      end else begin
         since <= (DIN != din_q) ? 0 : since + ((since < 1000) ? 1 : 0);
         din_q <= DIN;
         acc_q <= {acc_q[1:0], RD | WR};
         ow_q <= {ow_q[0], WR && ADDR == ADDR_OUTPUT};
         {rd_q, ra_q} <= {RD, ADDR};
         irq_q <= IRQ;
         if (DIN != din_q) begin
            snap_ok <= 1'b0;
         end else if (IRQ && !irq_q && acc_q == 3'h0 && since > SETTLE_CYCLES) begin
            snap_ok <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence glitch_s;
      $changed(DIN) ##1 $changed(DIN);
   endsequence
   read_idle_a: assert property (!rd_q |-> RDATA == 32'h0)
      else $error("read data not zero");
   word_upper_a: assert property (rd_q |-> {RDATA[31:24], RDATA[15:8]} == 16'h0)
      else $error("upper bits set");
   out_write_a: assert property (ow_q[1] |-> DOUT_ON == 8'($past(WDATA, 2)))
      else $error("output value wrong");
   out_hold_a: assert property ($changed(DOUT_ON) |-> ow_q[1])
      else $error("output moved without write");
   glitch_reject_a: assert property (glitch_s |-> (!$rose(IRQ)) [*8])
      else $error("glitch raised irq");
   irq_fall_a: assert property ($fell(IRQ) |-> acc_q != 3'h0)
      else $error("irq fell by itself");
   irq_rise_a: assert property ($rose(IRQ) && acc_q == 3'h0 |-> since >= SETTLE_CYCLES)
      else $error("irq before settling");
   input_read_a: assert property (
      rd_q && ra_q == ADDR_INPUT && since > SETTLE_CYCLES + 4 |-> RDATA[7:0] == DIN)
      else $error("input read wrong");
   event_snap_a: assert property (
      rd_q && ra_q == ADDR_EVENT && snap_ok && $stable(DIN) |-> RDATA[23:16] == DIN)
      else $error("snapshot wrong");
endmodule

bind dio_port dio_port_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) dio_port_properties_i (.*);

/* File: verification/field_src.sv */
// Field-side model that drives the isolated input lines.
`timescale 1ns/1ps
module field_src (
   input wire logic clk,
   input wire logic [7:0] lvl,
   input wire logic [7:0] bnc,
   output logic [7:0] din
);
   logic t = 1'b0;
   // A bouncing line flips every cycle, so it never looks like a held level.
   always @(posedge clk) t <= ~t;
   assign din = lvl ^ (bnc & {8{t}});
endmodule

/* File: verification/isolated_dio_port_change_irq_tb_top.sv */
// Self-checking bench for the isolated digital I/O port.
`timescale 1ns/1ps
module isolated_dio_port_change_irq_tb_top;
   import dio_pkg::*;
   localparam int ST = 4;
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic IRQ;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] DIN;
   logic [7:0] DOUT_ON;
   logic [7:0] lvl = 8'h00;
   logic [7:0] bnc = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic [31:0] RDATA;
   logic [31:0] v;
   int n_errors = 0;
   int cmp_count = 0;
   always #5 SYS_CLK = ~SYS_CLK;
   field_src field_src_i (.clk(SYS_CLK), .lvl(lvl), .bnc(bnc), .din(DIN));
   dio_port #(.SETTLE_CYCLES(ST)) dio_port_i (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus cycle; read data stand only in the cycle after the strobe.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      {WR, RD, ADDR, WDATA} <= {w, !w, a, d};
      @(posedge SYS_CLK);
      {WR, RD} <= 2'b00;
      #1 v = RDATA;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic t_port;
      settle(1);
      chk(32'({DOUT_ON, IRQ}), 32'h0);
      bus(1'b1, ADDR_OUTPUT, 32'hA5);
      settle(2);
      chk(32'(DOUT_ON), 32'hA5);
      bus(1'b0, ADDR_OUTPUT, 32'h0);
      chk(v, 32'hA5);
      bus(1'b0, 4'hF, 32'h0);
      chk(v, 32'h0);
      @(posedge SYS_CLK) lvl <= 8'h3C;
      settle(ST + 6);
      chk(32'(IRQ), 32'h0);
      bus(1'b0, ADDR_INPUT, 32'h0);
      chk(v, 32'h3C);
   endtask
   task automatic t_cos;
      bus(1'b1, ADDR_CONTROL, 32'h1);
      bus(1'b1, ADDR_IRQ_ENABLE, 32'h1);
      @(posedge SYS_CLK) lvl <= 8'h3E;
      settle(ST + 8);
      chk(32'(IRQ), 32'h0);
      @(posedge SYS_CLK) lvl <= 8'h3F;
      for (int i = 0; i < 20 && IRQ !== 1'b1; i++) settle(1);
      chk(32'(IRQ), 32'h1);
      bus(1'b0, ADDR_EVENT, 32'h0);
      chk(v, 32'h003F_0001);
      settle(3);
      chk(32'(IRQ), 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(v, 32'h1);
      bus(1'b1, ADDR_INT_ENABLE, 32'h1);
      settle(2);
      chk(32'(IRQ), 32'h1);
      bus(1'b1, ADDR_CLEAR, 32'h1);
      settle(2);
      chk(32'(IRQ), 32'h0);
   endtask
   task automatic t_glitch;
      @(posedge SYS_CLK) bnc <= 8'h01;
      repeat (2) @(posedge SYS_CLK);
      bnc <= 8'h00;
      settle(ST + 8);
      chk(32'(IRQ), 32'h0);
      bus(1'b0, ADDR_INPUT, 32'h0);
      chk(v, 32'h3F);
   endtask
   // Line 1 kept its earlier change while masked, so enabling it raises a first event.
   task automatic t_overrun;
      bus(1'b1, ADDR_IRQ_ENABLE, 32'h3);
      @(posedge SYS_CLK) lvl <= 8'h3E;
      settle(ST + 8);
      chk(32'(IRQ), 32'h1);
      bus(1'b0, ADDR_EVENT, 32'h0);
      chk(v, 32'h003E_0003);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(v, 32'h3);
      bus(1'b1, ADDR_CLEAR, 32'h3);
      settle(2);
      chk(32'(IRQ), 32'h0);
      @(posedge SYS_CLK) RST_N <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      settle(1);
      chk(32'({DOUT_ON, IRQ}), 32'h0);
   endtask
   task automatic results;
      $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      t_port();
      t_cos();
      t_glitch();
      t_overrun();
      results();
   end
   // The whole run is about 110 cycles; this limit leaves a wide margin.
   initial begin
      #20000;
      n_errors++;
      results();
   end
endmodule
